// >>> hw/tcsi_pkg.sv
// Constants shared by the timer channel status and interrupt block
`default_nettype none
package tcsi_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned EVT_W  = 8;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h04;
  localparam logic [7:0] OFS_IRQ_DIS  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_MODE     = 8'h10;

  // ==========================================================================
  // Event bit positions, shared by status, enable, disable and mask
  localparam int unsigned BIT_OVF  = 0;
  localparam int unsigned BIT_LOVR = 1;
  localparam int unsigned BIT_CMPA = 2;
  localparam int unsigned BIT_CMPB = 3;
  localparam int unsigned BIT_CMPC = 4;
  localparam int unsigned BIT_LDRA = 5;
  localparam int unsigned BIT_LDRB = 6;
  localparam int unsigned BIT_TRIG = 7;

  // ==========================================================================
  // Level bits of the status word and the mode register
  localparam int unsigned BIT_CLK_ON = 16;
  localparam int unsigned BIT_MIR_A  = 17;
  localparam int unsigned BIT_MIR_B  = 18;
  localparam int unsigned BIT_WAVE   = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic [7:0]  RST_MASK  = 8'h00;
  localparam logic        RST_WAVE  = 1'b0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  localparam logic [1:0]  RST_SYNC  = 2'h0;

endpackage
`default_nettype wire

// >>> hw/tcsi_sync2.sv
// Two-flop synchroniser for the two channel line pins
`default_nettype none
`timescale 1ns/1ps
module tcsi_sync2 (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic [1:0] i_d,
  output logic      [1:0] o_q
);

  // ==========================================================================
  // Stages
  logic [1:0] meta_r;
  logic [1:0] sync_r;

  // First stage is read by the second stage only
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= tcsi_pkg::RST_SYNC;
      sync_r <= tcsi_pkg::RST_SYNC;
    end else begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end

  assign o_q = sync_r;

endmodule
`default_nettype wire

// >>> hw/tcsi_load_track.sv
// Load overrun tracker for one capture register
`default_nettype none
`timescale 1ns/1ps
module tcsi_load_track (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_en,
  input  wire logic i_load,
  input  wire logic i_read,
  output logic      o_overrun
);

  // ==========================================================================
  // Unread-load tracking
  logic pend_r;
  logic pend_nxt;

  // A read in the same cycle as a load consumes the older value only
  assign pend_nxt  = !i_en ? 1'b0 : (i_load ? 1'b1 : (i_read ? 1'b0 : pend_r));
  assign o_overrun = i_en & i_load & pend_r & ~i_read; // RL13

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  second_load_a: assert property ( // RL13
    (i_en && i_load && !i_read) ##1 (i_en && i_load && !i_read) |-> o_overrun)
    else $error("second unread load gave no overrun");

  gapped_load_a: assert property ( // RL13
    (i_en && i_load && !i_read) ##1 (i_en && !i_read) ##1 (i_en && i_load && !i_read) |-> o_overrun)
    else $error("load after an idle gap gave no overrun");

endmodule
`default_nettype wire

// >>> hw/tcsi_top.sv
// Timer channel event status, interrupt mask and register slave
//
// Overview of operation
// RL1: Register B load sets its flag in capture mode only, held until status read.
// RL2: External trigger sets its flag in either mode, held until status read.
// RL3: Reading the status register clears every latched event flag.
// RL4: Status shows whether the counter clock runs; reading does not clear it.
// RL5: Status mirrors line A: pin level in capture, driven level in waveform.
// RL6: Status mirrors line B: pin level in capture, driven level in waveform.
// RL7: Writing ones to the enable register sets those mask bits, zeros ignored.
// RL8: Writing ones to the disable register clears those mask bits, zeros ignored.
// RL9: Overrun and load events count in capture, A and B compares in waveform.
// RL10: The mask register reads back enabled events in enable-register order.
// RL11: Enable and disable registers are write-only and read back zero.
// RL12: Mode bit one selects waveform mode, zero selects capture mode.
// RL13: Capture mode flags overrun when A or B loads twice unread.
// RL14: Counter overflow sets its flag, held until the next status read.
// RL15: Interrupt is high while any latched flag has its mask bit set.
// RL16: An event in the same cycle as a status read survives the clear.
//
// Our own choices: the register addresses and the plain strobed port.
`default_nettype none
`timescale 1ns/1ps
module tcsi_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_ovf_evt,
  input  wire logic        i_cmp_a_evt,
  input  wire logic        i_cmp_b_evt,
  input  wire logic        i_cmp_c_evt,
  input  wire logic        i_ra_load_evt,
  input  wire logic        i_rb_load_evt,
  input  wire logic        i_trig_evt,
  input  wire logic        i_ra_read,
  input  wire logic        i_rb_read,
  input  wire logic        i_clk_running,
  input  wire logic        i_line_a_pin,
  input  wire logic        i_line_b_pin,
  input  wire logic        i_line_a_drv,
  input  wire logic        i_line_b_drv,
  output logic             o_wave_mode,
  output logic             o_irq
);

  // ==========================================================================
  // State
  logic [7:0]  flag_r;
  logic [7:0]  flag_nxt;
  logic [7:0]  mask_r;
  logic [7:0]  mask_nxt;
  logic        wave_r;
  logic        wave_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        irq_r;
  logic        irq_nxt;

  // ==========================================================================
  // Helpers shared by several decodes
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return (addr == ofs);
  endfunction

  // Mirror source follows the mode bit; pins arrive through the synchroniser
  function automatic logic mirror_sel(input logic wave, input logic drv, input logic pin);
    return wave ? drv : pin;
  endfunction

  // ==========================================================================
  // Address decode
  logic hit_status;
  logic hit_en;
  logic hit_dis;
  logic hit_mask;
  logic hit_mode;

  assign hit_status = addr_hit(i_addr, tcsi_pkg::OFS_STATUS);
  assign hit_en     = addr_hit(i_addr, tcsi_pkg::OFS_IRQ_EN);
  assign hit_dis    = addr_hit(i_addr, tcsi_pkg::OFS_IRQ_DIS);
  assign hit_mask   = addr_hit(i_addr, tcsi_pkg::OFS_IRQ_MASK);
  assign hit_mode   = addr_hit(i_addr, tcsi_pkg::OFS_MODE);

  logic rd_status;
  logic wr_en;
  logic wr_dis;
  logic wr_mode;

  assign rd_status = i_rd & hit_status;
  assign wr_en     = i_wr & hit_en;
  assign wr_dis    = i_wr & hit_dis;
  assign wr_mode   = i_wr & hit_mode;

  // ==========================================================================
  // Pin lines and overrun trackers
  logic [1:0] pin_s;
  logic       ovr_a;
  logic       ovr_b;
  logic       cap_mode;

  assign cap_mode = ~wave_r;

  tcsi_sync2 u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_d     ({i_line_b_pin, i_line_a_pin}),
    .o_q     (pin_s)
  );

  tcsi_load_track u_trk_a (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_en      (cap_mode),
    .i_load    (i_ra_load_evt),
    .i_read    (i_ra_read),
    .o_overrun (ovr_a)
  );

  tcsi_load_track u_trk_b (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_en      (cap_mode),
    .i_load    (i_rb_load_evt),
    .i_read    (i_rb_read),
    .o_overrun (ovr_b)
  );

  // ==========================================================================
  // Event flags
  logic [7:0] evt_set;

  always_comb begin
    evt_set = 8'h00;
    evt_set[tcsi_pkg::BIT_OVF]  = i_ovf_evt; // RL14
    evt_set[tcsi_pkg::BIT_LOVR] = cap_mode & (ovr_a | ovr_b); // RL9 RL13
    evt_set[tcsi_pkg::BIT_CMPA] = wave_r & i_cmp_a_evt; // RL9
    evt_set[tcsi_pkg::BIT_CMPB] = wave_r & i_cmp_b_evt; // RL9
    evt_set[tcsi_pkg::BIT_CMPC] = i_cmp_c_evt;
    evt_set[tcsi_pkg::BIT_LDRA] = cap_mode & i_ra_load_evt; // RL9
    evt_set[tcsi_pkg::BIT_LDRB] = cap_mode & i_rb_load_evt; // RL1
    evt_set[tcsi_pkg::BIT_TRIG] = i_trig_evt; // RL2
  end

  // Set wins over the read clear
  assign flag_nxt = (rd_status ? tcsi_pkg::RST_FLAGS : flag_r) | evt_set; // RL3 RL16

  // ==========================================================================
  // Mask and mode
  assign mask_nxt = wr_en  ? (mask_r | i_wdata[7:0]) : // RL7
                    wr_dis ? (mask_r & ~i_wdata[7:0]) : // RL8
                    mask_r;
  assign wave_nxt = wr_mode ? i_wdata[tcsi_pkg::BIT_WAVE] : wave_r; // RL12

  // Interrupt tracks the next state so it lines up with the flags
  assign irq_nxt = |(flag_nxt & mask_nxt); // RL15

  // ==========================================================================
  // Read data
  logic        mir_a;
  logic        mir_b;
  logic [31:0] status_word;
  logic [31:0] mask_word;

  assign mir_a = mirror_sel(wave_r, i_line_a_drv, pin_s[0]); // RL5
  assign mir_b = mirror_sel(wave_r, i_line_b_drv, pin_s[1]); // RL6

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[7:0] = flag_r;
    status_word[tcsi_pkg::BIT_CLK_ON] = i_clk_running; // RL4
    status_word[tcsi_pkg::BIT_MIR_A]  = mir_a;
    status_word[tcsi_pkg::BIT_MIR_B]  = mir_b;
  end

  assign mask_word = {24'h00_0000, mask_r}; // RL10

  // Write-only and unmapped addresses read as zero
  assign rdata_nxt = !i_rd     ? tcsi_pkg::RST_RDATA :
                     hit_status ? status_word :
                     hit_mask   ? mask_word :
                     hit_mode   ? {31'h0000_0000, wave_r} :
                     tcsi_pkg::RST_RDATA; // RL11

  // ==========================================================================
  // Registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flag_r  <= tcsi_pkg::RST_FLAGS;
      mask_r  <= tcsi_pkg::RST_MASK;
      wave_r  <= tcsi_pkg::RST_WAVE;
      rdata_r <= tcsi_pkg::RST_RDATA;
      irq_r   <= 1'b0;
    end else begin
      flag_r  <= flag_nxt;
      mask_r  <= mask_nxt;
      wave_r  <= wave_nxt;
      rdata_r <= rdata_nxt;
      irq_r   <= irq_nxt;
    end
  end

  assign o_rdata     = rdata_r;
  assign o_irq       = irq_r;
  assign o_wave_mode = wave_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  rb_load_flag_a: assert property ( // RL1
    (cap_mode && i_rb_load_evt) |=> flag_r[tcsi_pkg::BIT_LDRB])
    else $error("capture load of B did not set its flag");

  trig_flag_a: assert property ( // RL2
    i_trig_evt |=> flag_r[tcsi_pkg::BIT_TRIG])
    else $error("trigger did not set its flag");

  status_clear_a: assert property ( // RL3
    (rd_status && evt_set == 8'h00) |=> flag_r == 8'h00 && o_rdata[7:0] == $past(flag_r))
    else $error("status read did not clear flags");

  clk_on_read_a: assert property ( // RL4
    rd_status |=> o_rdata[tcsi_pkg::BIT_CLK_ON] == $past(i_clk_running))
    else $error("clock running bit wrong");

  mirror_line_a_a: assert property ( // RL5
    (rd_status && wave_r) |=> o_rdata[tcsi_pkg::BIT_MIR_A] == $past(i_line_a_drv))
    else $error("line A mirror wrong in waveform mode");

  mirror_line_b_a: assert property ( // RL6
    (rd_status && cap_mode) |=> o_rdata[tcsi_pkg::BIT_MIR_B] == $past(i_line_b_pin, 3))
    else $error("line B mirror wrong in capture mode");

  irq_enable_a: assert property ( // RL7
    wr_en |=> (mask_r & $past(i_wdata[7:0])) == $past(i_wdata[7:0])
              && (mask_r | $past(mask_r)) == mask_r)
    else $error("enable write did not set mask");

  irq_disable_a: assert property ( // RL8
    wr_dis |=> (mask_r & $past(i_wdata[7:0])) == 8'h00 && (mask_r & ~$past(mask_r)) == 8'h00)
    else $error("disable write did not clear mask");

  mode_gate_a: assert property ( // RL9
    (wave_r && !flag_r[tcsi_pkg::BIT_LDRA] && !i_wr) |=> !flag_r[tcsi_pkg::BIT_LDRA])
    else $error("load flag set in waveform mode");

  mask_read_a: assert property ( // RL10
    (i_rd && hit_mask) |=> o_rdata == {24'h00_0000, $past(mask_r)})
    else $error("mask readback wrong");

  wo_read_a: assert property ( // RL11
    (i_rd && (hit_en || hit_dis)) |=> o_rdata == 32'h0000_0000)
    else $error("write-only register read nonzero");

  mode_write_a: assert property ( // RL12
    wr_mode |=> o_wave_mode == $past(i_wdata[tcsi_pkg::BIT_WAVE]))
    else $error("mode bit not taken");

  overflow_flag_a: assert property ( // RL14
    i_ovf_evt |=> flag_r[tcsi_pkg::BIT_OVF])
    else $error("overflow did not set flag");

  irq_level_a: assert property ( // RL15
    o_irq == |(flag_r & mask_r))
    else $error("interrupt level disagrees with flags and mask");

  read_race_a: assert property ( // RL16
    (rd_status && evt_set != 8'h00) |=> flag_r == $past(evt_set))
    else $error("event lost under status read");

  cmp_gate_a: assert property ( // RL9
    (cap_mode && !flag_r[tcsi_pkg::BIT_CMPA] && !flag_r[tcsi_pkg::BIT_CMPB])
    |=> !flag_r[tcsi_pkg::BIT_CMPA] && !flag_r[tcsi_pkg::BIT_CMPB])
    else $error("compare A or B flag set in capture mode");

  overrun_gate_a: assert property ( // RL13
    (wave_r && !flag_r[tcsi_pkg::BIT_LOVR]) |=> !flag_r[tcsi_pkg::BIT_LOVR])
    else $error("overrun flag set in waveform mode");

  load_b_gate_a: assert property ( // RL1
    (wave_r && !flag_r[tcsi_pkg::BIT_LDRB]) |=> !flag_r[tcsi_pkg::BIT_LDRB])
    else $error("load B flag set in waveform mode");

  cmp_c_flag_a: assert property ( // RL9
    i_cmp_c_evt |=> flag_r[tcsi_pkg::BIT_CMPC])
    else $error("compare C did not set its flag");

  flag_hold_a: assert property ( // RL3
    !rd_status |=> (flag_r & $past(flag_r)) == $past(flag_r))
    else $error("flag dropped without a status read");

  mask_block_a: assert property ( // RL15
    (mask_r == 8'h00 && !wr_en) |=> !o_irq)
    else $error("interrupt raised with empty mask");

  rdata_idle_a: assert property ( // RL11
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data nonzero outside a read");

  mirror_pin_a_a: assert property ( // RL5
    (rd_status && cap_mode) |=> o_rdata[tcsi_pkg::BIT_MIR_A] == $past(i_line_a_pin, 3))
    else $error("line A mirror wrong in capture mode");

  mirror_drv_b_a: assert property ( // RL6
    (rd_status && wave_r) |=> o_rdata[tcsi_pkg::BIT_MIR_B] == $past(i_line_b_drv))
    else $error("line B mirror wrong in waveform mode");

  irq_rise_c:   cover property (!o_irq ##1 o_irq);
  race_c:       cover property (rd_status && i_trig_evt);
  overrun_c:    cover property (evt_set[tcsi_pkg::BIT_LOVR]);
  wave_cmp_c:   cover property (wave_r && i_cmp_a_evt);

endmodule
`default_nettype wire

// >>> verif/tcsi_evt_src.sv
// Event source model standing in for the counter and capture datapath
`timescale 1ns/1ps
`default_nettype none
module tcsi_evt_src (
  input  wire logic       i_clk,
  output logic      [8:0] o_evt
);
  // ==========================================================
  // Pulse driver
  // Bits: 0 ovf, 1 read A, 2-4 cmp A/B/C, 5-6 load A/B, 7 trig, 8 read B
  initial o_evt = 9'h000;
  // One cycle only, so a held pulse never fakes a second load
  task automatic pulse(input logic [8:0] e);
    @(posedge i_clk);
    o_evt <= e;
    @(posedge i_clk);
    o_evt <= 9'h000;
  endtask
endmodule
`default_nettype wire

// >>> verif/test_timer_channel_status_irq.sv
// Self-checking bench for the timer channel status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module test_timer_channel_status_irq;
  // ==========================================================
  // Stimulus and scoreboard state
  logic        i_clk   = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [7:0]  i_addr  = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr    = 1'b0;
  logic        i_rd    = 1'b0;
  logic        clk_run = 1'b0;
  logic        wave    = 1'b0;
  logic        rd_q    = 1'b0;
  logic [1:0]  line_pin = 2'h0;
  logic [1:0]  line_drv = 2'h0;
  logic [31:0] o_rdata;
  logic        o_wave_mode;
  logic        o_irq;
  logic [8:0]  evt;
  logic [7:0]  rnd;
  logic [31:0] exp_q[$];
  int          errors  = 0;
  int          n_tests = 0;
  int          seed    = 32'he423;

  always #4 i_clk = ~i_clk;

  tcsi_evt_src src_u (.i_clk(i_clk), .o_evt(evt));

  // Random pin levels, driven levels their inverse, so the mirror source shows
  tcsi_top dut_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_ovf_evt(evt[0]), .i_cmp_a_evt(evt[2]), .i_cmp_b_evt(evt[3]),
    .i_cmp_c_evt(evt[4]), .i_ra_load_evt(evt[5]), .i_rb_load_evt(evt[6]),
    .i_trig_evt(evt[7]), .i_ra_read(evt[1]), .i_rb_read(evt[8]),
    .i_clk_running(clk_run), .i_line_a_pin(line_pin[0]), .i_line_b_pin(line_pin[1]),
    .i_line_a_drv(line_drv[0]), .i_line_b_drv(line_drv[1]),
    .o_wave_mode(o_wave_mode), .o_irq(o_irq));

  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask

  task automatic chk_irq(input logic e);
    @(negedge i_clk);
    check({31'h0, o_irq}, {31'h0, e});
  endtask

  // Level bits: line B, line A, counter clock, then the event flags
  function automatic logic [31:0] st(input logic [7:0] f);
    return {13'h0, (wave ? line_drv[1] : line_pin[1]), (wave ? line_drv[0] : line_pin[0]), clk_run, 8'h00, f};
  endfunction

  // ==========================================================
  // Read data monitor
  always @(posedge i_clk) rd_q <= i_rd;
  always @(negedge i_clk) begin
    if (rd_q) begin
      check(o_rdata, exp_q.pop_front());
    end else begin
      check(o_rdata, 32'h0);
    end
  end

  initial begin
    repeat (5000) @(posedge i_clk);
    errors++;
    complete_run();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    rnd = 8'($random(seed));
    line_pin <= rnd[1:0];
    line_drv <= ~rnd[1:0];
    i_rst_b <= 1'b1;
    bus_rd(tcsi_pkg::OFS_IRQ_MASK, 32'h0);
    bus_rd(tcsi_pkg::OFS_IRQ_EN, 32'h0);
    bus_rd(tcsi_pkg::OFS_IRQ_DIS, 32'h0);
    bus_rd(8'h20, 32'h0);
    rnd = 8'($random(seed));
    bus_wr(tcsi_pkg::OFS_IRQ_EN, {24'h0, rnd});
    bus_wr(tcsi_pkg::OFS_IRQ_EN, 32'h0);
    bus_rd(tcsi_pkg::OFS_IRQ_MASK, {24'h0, rnd});
    bus_wr(tcsi_pkg::OFS_IRQ_EN, 32'hff);
    bus_wr(tcsi_pkg::OFS_IRQ_DIS, 32'h0f);
    bus_rd(tcsi_pkg::OFS_IRQ_MASK, 32'hf0);
    // Capture mode: compares A and B must be dropped
    clk_run <= 1'b1;
    src_u.pulse(9'h0fd);
    src_u.pulse(9'h020);
    bus_rd(tcsi_pkg::OFS_STATUS, st(8'hf3));
    src_u.pulse(9'h002);
    src_u.pulse(9'h020);
    src_u.pulse(9'h002);
    src_u.pulse(9'h020);
    bus_rd(tcsi_pkg::OFS_STATUS, st(8'h20));
    bus_rd(tcsi_pkg::OFS_STATUS, st(8'h00));
    // Waveform mode: loads and overrun must be dropped
    clk_run <= 1'b0;
    bus_wr(tcsi_pkg::OFS_MODE, 32'h1);
    wave = 1'b1;
    @(negedge i_clk);
    check({31'h0, o_wave_mode}, 32'h1);
    bus_rd(tcsi_pkg::OFS_MODE, 32'h1);
    src_u.pulse(9'h0fd);
    bus_rd(tcsi_pkg::OFS_STATUS, st(8'h9d));
    // Interrupt follows masked-in flags only
    bus_wr(tcsi_pkg::OFS_IRQ_DIS, 32'hff);
    bus_wr(tcsi_pkg::OFS_IRQ_EN, 32'h01);
    src_u.pulse(9'h080);
    chk_irq(1'b0);
    src_u.pulse(9'h001);
    chk_irq(1'b1);
    bus_rd(tcsi_pkg::OFS_STATUS, st(8'h81));
    chk_irq(1'b0);
    // Event landing on the clearing read survives it
    fork
      bus_rd(tcsi_pkg::OFS_STATUS, st(8'h00));
      src_u.pulse(9'h080);
    join
    bus_rd(tcsi_pkg::OFS_STATUS, st(8'h80));
    // Mid-run reset, one edge after the last read data has been checked
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    wave = 1'b0;
    bus_rd(tcsi_pkg::OFS_IRQ_MASK, 32'h0);
    bus_rd(tcsi_pkg::OFS_MODE, 32'h0);
    bus_rd(tcsi_pkg::OFS_STATUS, st(8'h00));
    repeat (2) @(posedge i_clk);
    complete_run();
  end
endmodule
`default_nettype wire
